// ---- hw/mfr_regs.sv ----
/*
  register bank of the modem: buffer bases and host pointer, interrupt
  mask and write-one-to-clear flags, received packet report, header and
  packet counters, modem state and packet noise ratio.
  assumes a simple register port already decoded from the serial link
  (one-cycle write and read strobes) and event pulses from the modem.
*/
`timescale 1ns/1ps
module mfr_regs (
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // modem side
  input wire logic [1:0] op_mode,
  input wire logic receive_timeout_event,
  input wire logic receive_complete_event,
  input wire logic payload_check_failure_event,
  input wire logic header_accepted_event,
  input wire logic transmit_complete_event,
  input wire logic activity_scan_complete_event,
  input wire logic hop_channel_change_event,
  input wire logic activity_found_event,
  input wire logic [2:0] header_code_rate,
  input wire logic [7:0] packet_start,
  input wire logic [7:0] packet_length,
  input wire logic [7:0] packet_snr_estimate,
  input wire logic [4:0] modem_state_bits,
  input wire logic buffer_access_step,
  // configuration and signalling toward the modem
  output logic [7:0] tx_buffer_base,
  output logic [7:0] rx_buffer_base,
  output logic [7:0] host_buffer_pointer,
  output logic [7:0] interrupt_signal
);

  logic [7:0] interrupt_mask;
  logic [7:0] interrupt_flags;
  logic [7:0] next_interrupt_flags;
  logic [7:0] event_vector;
  logic [7:0] clear_vector;
  logic [7:0] last_packet_start;
  logic [7:0] rx_payload_length;
  logic [7:0] packet_noise_ratio;
  logic [2:0] received_code_rate;
  logic [15:0] header_count;
  logic [15:0] packet_count;
  logic [7:0] next_rdata;
  logic in_sleep;
  logic in_receive;
  logic was_receive;
  logic counter_clear;
  logic packet_valid;

  // write strobes, one per writable register
  logic wr_pointer;
  logic wr_tx_base;
  logic wr_rx_base;
  logic wr_mask;
  logic wr_flags;

  always_comb begin
    wr_pointer = 1'b0;
    wr_tx_base = 1'b0;
    wr_rx_base = 1'b0;
    wr_mask = 1'b0;
    wr_flags = 1'b0;
    if (reg_write && reg_addr == mfr_pkg::OFS_HOST_BUFFER_POINTER) begin
      wr_pointer = 1'b1;
    end else if (reg_write && reg_addr == mfr_pkg::OFS_TX_BUFFER_BASE) begin
      wr_tx_base = 1'b1;
    end else if (reg_write && reg_addr == mfr_pkg::OFS_RX_BUFFER_BASE) begin
      wr_rx_base = 1'b1;
    end else if (reg_write && reg_addr == mfr_pkg::OFS_INTERRUPT_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_write && reg_addr == mfr_pkg::OFS_INTERRUPT_FLAGS) begin
      wr_flags = 1'b1;
    end
  end

  // host buffer pointer; a host write beats the step from a buffer access
  always_ff @(posedge clock) begin
    if (rst) begin
      host_buffer_pointer <= mfr_pkg::RST_HOST_BUFFER_POINTER;
    end else if (wr_pointer) begin
      host_buffer_pointer <= reg_wdata;
    end else if (buffer_access_step) begin
      host_buffer_pointer <= host_buffer_pointer + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tx_buffer_base <= mfr_pkg::RST_TX_BUFFER_BASE;
    end else if (wr_tx_base) begin
      tx_buffer_base <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rx_buffer_base <= mfr_pkg::RST_RX_BUFFER_BASE;
    end else if (wr_rx_base) begin
      rx_buffer_base <= reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      interrupt_mask <= mfr_pkg::RST_INTERRUPT_MASK;
    end else if (wr_mask) begin
      interrupt_mask <= reg_wdata;
    end
  end

  // flag layout gathered into one vector
  always_comb begin
    event_vector = 8'h00;
    event_vector[mfr_pkg::BIT_RECEIVE_TIMEOUT] = receive_timeout_event;
    event_vector[mfr_pkg::BIT_RECEIVE_COMPLETE] = receive_complete_event;
    event_vector[mfr_pkg::BIT_PAYLOAD_CHECK_FAILURE] = payload_check_failure_event;
    event_vector[mfr_pkg::BIT_HEADER_ACCEPTED] = header_accepted_event;
    event_vector[mfr_pkg::BIT_TRANSMIT_COMPLETE] = transmit_complete_event;
    event_vector[mfr_pkg::BIT_ACTIVITY_SCAN_COMPLETE] = activity_scan_complete_event;
    event_vector[mfr_pkg::BIT_HOP_CHANNEL_CHANGE] = hop_channel_change_event;
    event_vector[mfr_pkg::BIT_ACTIVITY_FOUND] = activity_found_event;
  end

  // only ones written clear; zeros leave the flag alone
  assign clear_vector = wr_flags ? reg_wdata : 8'h00;

  // per flag: an event in the clearing cycle survives, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < mfr_pkg::FLAG_N; gi = gi + 1) begin : g_flag
      always_comb begin
        next_interrupt_flags[gi] = (interrupt_flags[gi] & ~clear_vector[gi])
          | event_vector[gi];
      end
      // mask bit only hides the signal; the flag itself still records
      assign interrupt_signal[gi] = interrupt_flags[gi] & ~interrupt_mask[gi];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (rst) begin
      interrupt_flags <= mfr_pkg::RST_INTERRUPT_FLAGS;
    end else begin
      interrupt_flags <= next_interrupt_flags;
    end
  end

  // packet report captured when reception completes
  always_ff @(posedge clock) begin
    if (rst) begin
      last_packet_start <= mfr_pkg::RST_CAPTURED;
      rx_payload_length <= mfr_pkg::RST_CAPTURED;
      packet_noise_ratio <= mfr_pkg::RST_CAPTURED;
    end else if (receive_complete_event) begin
      last_packet_start <= packet_start;
      rx_payload_length <= packet_length;
      packet_noise_ratio <= packet_snr_estimate;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      received_code_rate <= mfr_pkg::RST_CODE_RATE;
    end else if (header_accepted_event) begin
      received_code_rate <= header_code_rate;
    end
  end

  // counters restart on sleep and on each fresh entry into receive
  assign in_sleep = op_mode == mfr_pkg::MFR_MODE_SLEEP;
  assign in_receive = op_mode == mfr_pkg::MFR_MODE_RECEIVE;

  always_ff @(posedge clock) begin
    if (rst) begin
      was_receive <= 1'b0;
    end else begin
      was_receive <= in_receive;
    end
  end

  assign counter_clear = in_sleep || (in_receive && !was_receive);
  // a packet with a failed payload check is not a valid packet
  assign packet_valid = receive_complete_event && !payload_check_failure_event;

  mfr_count16 u_header_count (
    .clock(clock),
    .rst(rst),
    .clear(counter_clear),
    .inc(header_accepted_event),
    .count(header_count)
  );

  mfr_count16 u_packet_count (
    .clock(clock),
    .rst(rst),
    .clear(counter_clear),
    .inc(packet_valid),
    .count(packet_count)
  );

  // read decode; bytes of a counter are sampled live, not latched as a pair
  always_comb begin
    if (reg_addr == mfr_pkg::OFS_HOST_BUFFER_POINTER) begin
      next_rdata = host_buffer_pointer;
    end else if (reg_addr == mfr_pkg::OFS_TX_BUFFER_BASE) begin
      next_rdata = tx_buffer_base;
    end else if (reg_addr == mfr_pkg::OFS_RX_BUFFER_BASE) begin
      next_rdata = rx_buffer_base;
    end else if (reg_addr == mfr_pkg::OFS_LAST_PACKET_START) begin
      next_rdata = last_packet_start;
    end else if (reg_addr == mfr_pkg::OFS_INTERRUPT_MASK) begin
      next_rdata = interrupt_mask;
    end else if (reg_addr == mfr_pkg::OFS_INTERRUPT_FLAGS) begin
      next_rdata = interrupt_flags;
    end else if (reg_addr == mfr_pkg::OFS_RX_PAYLOAD_LENGTH) begin
      next_rdata = rx_payload_length;
    end else if (reg_addr == mfr_pkg::OFS_HEADER_COUNT_HIGH) begin
      next_rdata = header_count[15:8];
    end else if (reg_addr == mfr_pkg::OFS_HEADER_COUNT_LOW) begin
      next_rdata = header_count[7:0];
    end else if (reg_addr == mfr_pkg::OFS_PACKET_COUNT_HIGH) begin
      next_rdata = packet_count[15:8];
    end else if (reg_addr == mfr_pkg::OFS_PACKET_COUNT_LOW) begin
      next_rdata = packet_count[7:0];
    end else if (reg_addr == mfr_pkg::OFS_MODEM_STATE) begin
      next_rdata = {received_code_rate, modem_state_bits};
    end else if (reg_addr == mfr_pkg::OFS_PACKET_SNR) begin
      next_rdata = packet_noise_ratio;
    end else begin
      next_rdata = mfr_pkg::READ_UNMAPPED;
    end
  end

  // read data held until the next read
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= mfr_pkg::READ_UNMAPPED;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_read;
    end
  end

endmodule

// ---- hw/mfr_pkg.sv ----
/*
  constants for the modem buffer, interrupt and status register bank:
  register offsets, values after reset and interrupt flag positions.
  assumes a 7-bit register address space with 8-bit registers.
*/
package mfr_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int FLAG_N = 8;

  // register offsets
  localparam logic [6:0] OFS_HOST_BUFFER_POINTER = 7'h0D;
  localparam logic [6:0] OFS_TX_BUFFER_BASE = 7'h0E;
  localparam logic [6:0] OFS_RX_BUFFER_BASE = 7'h0F;
  localparam logic [6:0] OFS_LAST_PACKET_START = 7'h10;
  localparam logic [6:0] OFS_INTERRUPT_MASK = 7'h11;
  localparam logic [6:0] OFS_INTERRUPT_FLAGS = 7'h12;
  localparam logic [6:0] OFS_RX_PAYLOAD_LENGTH = 7'h13;
  localparam logic [6:0] OFS_HEADER_COUNT_HIGH = 7'h14;
  localparam logic [6:0] OFS_HEADER_COUNT_LOW = 7'h15;
  localparam logic [6:0] OFS_PACKET_COUNT_HIGH = 7'h16;
  localparam logic [6:0] OFS_PACKET_COUNT_LOW = 7'h17;
  localparam logic [6:0] OFS_MODEM_STATE = 7'h18;
  localparam logic [6:0] OFS_PACKET_SNR = 7'h19;

  // values after reset
  localparam logic [7:0] RST_HOST_BUFFER_POINTER = 8'h00;
  localparam logic [7:0] RST_TX_BUFFER_BASE = 8'h80;
  localparam logic [7:0] RST_RX_BUFFER_BASE = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_FLAGS = 8'h00;
  localparam logic [7:0] RST_CAPTURED = 8'h00;
  localparam logic [2:0] RST_CODE_RATE = 3'h0;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // interrupt flag bit positions
  localparam int BIT_RECEIVE_TIMEOUT = 7;
  localparam int BIT_RECEIVE_COMPLETE = 6;
  localparam int BIT_PAYLOAD_CHECK_FAILURE = 5;
  localparam int BIT_HEADER_ACCEPTED = 4;
  localparam int BIT_TRANSMIT_COMPLETE = 3;
  localparam int BIT_ACTIVITY_SCAN_COMPLETE = 2;
  localparam int BIT_HOP_CHANNEL_CHANGE = 1;
  localparam int BIT_ACTIVITY_FOUND = 0;

  // modem state byte layout
  localparam int CODE_RATE_LSB = 5;
  localparam int CODE_RATE_W = 3;
  localparam int STATUS_W = 5;

  // operating modes seen by this bank
  typedef enum logic [1:0] {
    MFR_MODE_SLEEP,
    MFR_MODE_IDLE,
    MFR_MODE_RECEIVE
  } mfr_mode_t;

endpackage

// ---- hw/mfr_count16.sv ----
/*
  16-bit event counter with a clear that beats the increment.
  assumes inc and clear are levels synchronous to clock; clear may stay high for many cycles.
*/
`timescale 1ns/1ps
module mfr_count16 (
  input wire logic clock,
  input wire logic rst,
  input wire logic clear,
  input wire logic inc,
  output logic [15:0] count
);

  // wraps at full scale; software reads two bytes and sees a modulo count
  always_ff @(posedge clock) begin
    if (rst || clear) begin
      count <= mfr_pkg::RST_COUNT;
    end else if (inc) begin
      count <= count + 16'h0001;
    end
  end

endmodule

// ---- sim/mfr_host.sv ----
/*
  host model: drives the register port of the bank one access at a time.
  assumes clock from the bench; signals change at the falling edge only.
*/
`timescale 1ns/1ps
module mfr_host (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  // a write leaves its address and inverts its data; a read inverts its address and leaves the data
  initial begin
    reg_addr = 7'h7F;
    reg_wdata = 8'hA5;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // one-to-clear and pointer writes go through here too
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask
  // answer is registered at the taking edge, so sample it at the falling edge after it
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic v);
    @(negedge clock);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge clock);
    d = reg_rdata;
    v = reg_rvalid;
    reg_read = 1'b0;
    reg_addr = ~a;
  endtask
endmodule

// ---- sim/mfr_regs_asserts.sv ----
/*
  checker for the register bank: register port and configuration outputs.
  assumes single clock domain, synchronous active-high reset.
*/
`timescale 1ns/1ps
module mfr_regs_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic reg_rvalid,
  input wire logic buffer_access_step,
  input wire logic [7:0] tx_buffer_base,
  input wire logic [7:0] rx_buffer_base,
  input wire logic [7:0] host_buffer_pointer
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence wr_tx; reg_write && reg_addr == 7'h0E; endsequence
  sequence wr_rx; reg_write && reg_addr == 7'h0F; endsequence
  sequence wr_ptr; reg_write && reg_addr == 7'h0D; endsequence
  read_answer_a: assert property (reg_read |=> reg_rvalid)
    else $error("read not answered next cycle");
  answer_cause_a: assert property (reg_rvalid |-> $past(reg_read))
    else $error("read answer without request");
  tx_write_a: assert property (wr_tx |=> tx_buffer_base == $past(reg_wdata))
    else $error("transmit base not written");
  rx_write_a: assert property (wr_rx |=> rx_buffer_base == $past(reg_wdata))
    else $error("receive base not written");
  ptr_write_a: assert property (wr_ptr |=> host_buffer_pointer == $past(reg_wdata))
    else $error("pointer not written");
  tx_hold_a: assert property (!(reg_write && reg_addr == 7'h0E) |=> $stable(tx_buffer_base))
    else $error("transmit base changed unasked");
  rx_hold_a: assert property (!(reg_write && reg_addr == 7'h0F) |=> $stable(rx_buffer_base))
    else $error("receive base changed unasked");
  ptr_step_a: assert property (buffer_access_step && !(reg_write && reg_addr == 7'h0D)
    |=> host_buffer_pointer == 8'($past(host_buffer_pointer) + 8'h01))
    else $error("pointer step wrong");
endmodule
bind mfr_regs mfr_regs_chk chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rvalid(reg_rvalid),
  .buffer_access_step(buffer_access_step), .tx_buffer_base(tx_buffer_base),
  .rx_buffer_base(rx_buffer_base), .host_buffer_pointer(host_buffer_pointer));

// ---- sim/test_mfr_regs.sv ----
/*
  self-checking bench for the register bank, host model on the port.
  assumes the one-cycle strobe register port of the bank.
*/
`timescale 1ns/1ps
module test_mfr_regs;
  logic clock, rst, reg_write, reg_read, reg_rvalid, step, v;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ev, txb, rxb, ptr, irq, d;
  logic [1:0] op_mode;
  logic [7:0] ps, pl, sn;
  logic [2:0] cr;
  int errors, tests_run;
  mfr_host host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
  mfr_regs uut (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .op_mode(op_mode), .receive_timeout_event(ev[7]),
    .receive_complete_event(ev[6]), .payload_check_failure_event(ev[5]),
    .header_accepted_event(ev[4]), .transmit_complete_event(ev[3]),
    .activity_scan_complete_event(ev[2]), .hop_channel_change_event(ev[1]),
    .activity_found_event(ev[0]), .header_code_rate(cr), .packet_start(ps),
    .packet_length(pl), .packet_snr_estimate(sn), .modem_state_bits(5'h0A),
    .buffer_access_step(step), .tx_buffer_base(txb), .rx_buffer_base(rxb),
    .host_buffer_pointer(ptr), .interrupt_signal(irq));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    host.rd(a, d, v);
    chk("rvalid", 8'h01, {7'h00, v});
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic pulse(input logic [7:0] e);
    @(negedge clock);
    ev = e;
    @(negedge clock);
    ev = 8'h00;
  endtask
  task automatic complete_run();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // whole run is a few hundred cycles; this leaves a wide margin
  initial begin
    #50000;
    errors++;
    complete_run();
  end
  initial begin
    logic [6:0] ra[13] = '{7'h0D, 7'h0E, 7'h0F, 7'h10, 7'h11, 7'h12, 7'h13, 7'h14,
      7'h15, 7'h16, 7'h17, 7'h19, 7'h7F};
    errors = 0;
    tests_run = 0;
    rst = 1'b1;
    ev = 8'h00;
    step = 1'b0;
    op_mode = 2'h1;
    cr = 3'h5;
    ps = 8'h37;
    pl = 8'h20;
    sn = 8'hF6;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    foreach (ra[i]) rdc(ra[i], ra[i] == 7'h0E ? 8'h80 : 8'h00);
    chk("txb", 8'h80, txb);
    chk("rxb", 8'h00, rxb);
    chk("ptr", 8'h00, ptr);
    chk("irq", 8'h00, irq);
    host.wr(7'h0E, 8'h3C);
    host.wr(7'h0F, 8'hC3);
    host.wr(7'h0D, 8'h05);
    // read-only place keeps its value
    host.wr(7'h13, 8'hFF);
    chk("txb", 8'h3C, txb);
    chk("rxb", 8'hC3, rxb);
    chk("ptr", 8'h05, ptr);
    rdc(7'h0E, 8'h3C);
    rdc(7'h0F, 8'hC3);
    rdc(7'h13, 8'h00);
    @(negedge clock);
    step = 1'b1;
    @(negedge clock);
    step = 1'b0;
    rdc(7'h0D, 8'h06);
    chk("ptr", 8'h06, ptr);
    for (int i = 0; i < 8; i++) begin
      pulse(8'h01 << i);
      chk("irq", 8'h01 << i, irq);
      rdc(7'h12, 8'h01 << i);
      host.wr(7'h12, ~(8'h01 << i));
      rdc(7'h12, 8'h01 << i);
      host.wr(7'h12, 8'h01 << i);
      rdc(7'h12, 8'h00);
    end
    host.wr(7'h11, 8'h40);
    pulse(8'h40);
    chk("masked irq", 8'h00, irq);
    // an event in the very cycle of its clear must survive
    fork
      host.wr(7'h12, 8'h08);
      pulse(8'h08);
    join
    chk("irq", 8'h08, irq);
    rdc(7'h12, 8'h48);
    host.wr(7'h11, 8'h00);
    chk("unmasked irq", 8'h48, irq);
    // captured values must not follow their inputs afterwards
    ps = 8'h11;
    pl = 8'h22;
    sn = 8'h0C;
    rdc(7'h10, 8'h37);
    rdc(7'h13, 8'h20);
    rdc(7'h19, 8'hF6);
    op_mode = 2'h2;
    repeat (3) pulse(8'h10);
    cr = 3'h2;
    pulse(8'h40);
    pulse(8'h60);
    rdc(7'h18, 8'hAA);
    rdc(7'h14, 8'h00);
    rdc(7'h15, 8'h03);
    rdc(7'h16, 8'h00);
    rdc(7'h17, 8'h01);
    rdc(7'h10, 8'h11);
    rdc(7'h13, 8'h22);
    rdc(7'h19, 8'h0C);
    // mode 3 is neither sleep nor receive: counters keep counting
    op_mode = 2'h3;
    pulse(8'h10);
    rdc(7'h15, 8'h04);
    op_mode = 2'h0;
    rdc(7'h15, 8'h00);
    rdc(7'h17, 8'h00);
    complete_run();
  end
endmodule
